/* include/vip_defs.vh */
// constants of the vectored interrupt priority logic
// assumes a single 50 MHz system clock and no bus; included by bare name
`ifndef VIP_DEFS_VH
`define VIP_DEFS_VH

// maskable source count and index width
`define VIP_NSRC 22
`define VIP_IDXW 5
// default priority index of each maskable source
`define VIP_I_WDT 0
`define VIP_I_PIN0 1
`define VIP_I_REMEDGE 5
`define VIP_I_SER 6
`define VIP_I_SER2 7
`define VIP_I_TX 8
`define VIP_I_WINT 9
`define VIP_I_TMA 10
`define VIP_I_TMB 11
`define VIP_I_TMC 12
`define VIP_I_TMD 13
`define VIP_I_ADC 14
`define VIP_I_WOVF 15
`define VIP_I_KEY0 16
`define VIP_I_RERR 17
`define VIP_I_RGUIDE 18
`define VIP_I_REND 19
`define VIP_I_RFULL 20
`define VIP_I_KEY1 21
// vector table: base 0004H, two-byte step per priority level
`define VIP_VEC_BASE 16'h0004
`define VIP_VEC_NMI 16'h0004
// reset values
`define VIP_MASK_RST 22'h3FFFFF
`define VIP_FLAG_RST 22'h000000
// pin edge select codes
`define VIP_EDGE_FALL 2'h0
`define VIP_EDGE_RISE 2'h1
`define VIP_EDGE_NONE 2'h2
`define VIP_EDGE_BOTH 2'h3
// watchdog mode select values
`define VIP_WDT_MODE1 1'h1
`define VIP_WDT_INTERVAL 1'h0
// pin count: four edge pins, two key return inputs
`define VIP_NPIN 6

`endif

/* hdl/vip_pin_edge.v */
// pin edge detection for the external maskable sources
// assumes pins are asynchronous to ref_clk; emits one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
`include "vip_defs.vh"

module vip_pin_edge (
  input wire ref_clk,
  input wire rstn,
  input wire [`VIP_NPIN-1:0] pin_in,
  input wire [2*`VIP_NPIN-1:0] edge_mode,
  output reg [`VIP_NPIN-1:0] edge_pulse
);

  reg [`VIP_NPIN-1:0] meta_reg;
  reg [`VIP_NPIN-1:0] sync_reg;
  reg [`VIP_NPIN-1:0] last_reg;
  reg [1:0] warm_reg;
  wire [`VIP_NPIN-1:0] hit;

  ////////////////////////////////////////////////////////////////
  // first stage feeds only the second one
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= {`VIP_NPIN{1'b0}};
      sync_reg <= {`VIP_NPIN{1'b0}};
      last_reg <= {`VIP_NPIN{1'b0}};
      warm_reg <= 2'h0;
      edge_pulse <= {`VIP_NPIN{1'b0}};
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
      if (warm_reg != 2'h3) begin
        warm_reg <= warm_reg + 2'h1;
      end
      // a high idle pin would look like a rising edge until the chain fills
      edge_pulse <= (warm_reg == 2'h3) ? hit : {`VIP_NPIN{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < `VIP_NPIN; g = g + 1) begin : g_pin
      wire [1:0] m;
      wire rise;
      wire fall;
      assign m = edge_mode[2*g+1:2*g];
      assign rise = sync_reg[g] & ~last_reg[g];
      assign fall = ~sync_reg[g] & last_reg[g];
      assign hit[g] = (m == `VIP_EDGE_RISE) ? rise :
                      (m == `VIP_EDGE_FALL) ? fall :
                      (m == `VIP_EDGE_BOTH) ? (rise | fall) : 1'b0;
    end
  endgenerate

endmodule
`default_nettype wire

/* hdl/vip_prio_enc.v */
// fixed priority encoder: lowest index wins
// assumes purely combinational use inside the controller
`timescale 1ns/100ps
`default_nettype none
`include "vip_defs.vh"

module vip_prio_enc (
  input wire [`VIP_NSRC-1:0] req,
  output wire found,
  output wire [`VIP_IDXW-1:0] index
);

  // a chain keeps the depth linear but small at 22 entries
  wire [`VIP_NSRC:0] taken;
  wire [`VIP_IDXW-1:0] pick [0:`VIP_NSRC];

  assign taken[0] = 1'b0;
  assign pick[0] = {`VIP_IDXW{1'b0}};

  genvar g;
  generate
    for (g = 0; g < `VIP_NSRC; g = g + 1) begin : g_lvl
      localparam [`VIP_IDXW-1:0] LVL = g;
      wire win;
      assign win = req[g] & ~taken[g];
      assign taken[g+1] = taken[g] | req[g];
      assign pick[g+1] = win ? LVL : pick[g];
    end
  endgenerate

  assign found = taken[`VIP_NSRC];
  assign index = pick[`VIP_NSRC];

endmodule
`default_nettype wire

/* hdl/vip_irq_ctrl.v */
// vectored interrupt priority logic: request flags, masks, vectors
// assumes peripheral events are one-cycle pulses on ref_clk,
// pins are asynchronous, and the cpu acks the presented vector
`timescale 1ns/100ps
`default_nettype none
`include "vip_defs.vh"

// Contract
// RULE1 - masked sources never reach the cpu
// RULE2 - simultaneous requests: level 0 wins
// RULE3 - any maskable request releases standby; the code releases it only for unmasked requests
// RULE4 - variants: 5 or 6 external sources
// RULE5 - extra key return: priority 21, 002EH
// RULE6 - watchdog mode 1 overflow raises nmi
// RULE7 - interval mode overflow: maskable, priority 0
// RULE8 - one watchdog path active at once
// RULE9 - edge pins: priorities 1-4, 0006H-000CH
// RULE10 - remote edge: priority 5, 000EH
// RULE11 - serial rx and 3-wire share priority 6
// RULE12 - second 3-wire end: priority 7, 0012H
// RULE13 - priorities 8-15: vectors 0014H-0022H
// RULE14 - cascade mode: combined match fires level 12
// RULE15 - first key return: priority 16, 0024H
// RULE16 - remote error/guide/end/full: levels 17-20
// RULE17 - flag sets on event, clears on ack/reset/write
// RULE18 - reset sets every mask flag
// RULE19 - nmi unconditional, outranks all maskable
// RULE20 - present best unmasked vector when enabled
module vip_irq_ctrl #(
  parameter LARGE_VARIANT = 1
) (
  input wire ref_clk,
  input wire rstn,
  // watchdog
  input wire watchdog_irq,
  input wire wdt_mode,
  // external pins
  input wire ext_pin0,
  input wire ext_pin1,
  input wire ext_pin2,
  input wire ext_pin3,
  input wire key_pin0,
  input wire key_pin1,
  input wire [1:0] ext_edge_mode_reg0,
  input wire [5:0] ext_edge_mode_reg1,
  input wire key_return_mode_reg0,
  input wire key_return_mode_reg1,
  // internal peripheral events
  input wire remote_edge_irq,
  input wire serial_rx_done_irq,
  input wire serial_3wire_done_irq,
  input wire second_3wire_done_irq,
  input wire serial_tx_done_irq,
  input wire watch_interval_irq,
  input wire timer_a_match_irq,
  input wire timer_b_match_irq,
  input wire timer_c_match_irq,
  input wire timer_d_match_irq,
  input wire timer_cascade,
  input wire adc_done_irq,
  input wire watch_overflow_irq,
  input wire remote_error_irq,
  input wire remote_guide_irq,
  input wire remote_end_irq,
  input wire remote_shift_full_irq,
  // software access
  input wire flag_wr,
  input wire [`VIP_NSRC-1:0] flag_wdata,
  input wire mask_wr,
  input wire [`VIP_NSRC-1:0] mask_wdata,
  // cpu side
  input wire global_irq_enable,
  input wire cpu_ack,
  output reg irq_req_reg,
  output reg irq_nmi_reg,
  output reg [`VIP_IDXW-1:0] irq_index_reg,
  output reg [15:0] irq_vector_reg,
  output reg standby_release_reg,
  output reg [`VIP_NSRC-1:0] req_flag_reg,
  output reg [`VIP_NSRC-1:0] mask_flag_reg,
  output reg nmi_pend_reg
);

  ////////////////////////////////////////////////////////////////
  // declarations
  wire [`VIP_NPIN-1:0] pin_raw;
  wire [2*`VIP_NPIN-1:0] pin_mode;
  wire [`VIP_NPIN-1:0] pin_edge;
  wire [`VIP_NSRC-1:0] src_event;
  wire [`VIP_NSRC-1:0] src_valid;
  wire [`VIP_NSRC-1:0] ack_hit;
  wire [`VIP_NSRC-1:0] flag_next;
  wire [`VIP_NSRC-1:0] mask_next;
  wire [`VIP_NSRC-1:0] live;
  wire wdt_nmi_mode;
  wire wdt_nmi_event;
  wire wdt_mask_event;
  wire cascade_match;
  wire tmc_event;
  wire ack_nmi;
  wire ack_mask;
  wire nmi_pend_next;
  wire enc_found;
  wire [`VIP_IDXW-1:0] enc_index;
  wire [`VIP_IDXW-1:0] sel_index;
  wire req_next;
  wire nmi_next;
  wire [15:0] vector_next;
  wire standby_next;

  ////////////////////////////////////////////////////////////////
  // external edge pins and key return inputs
  assign pin_raw = {key_pin1, key_pin0, ext_pin3, ext_pin2, ext_pin1, ext_pin0};
  // key return is a falling edge when enabled, silent otherwise
  assign pin_mode = {
    (key_return_mode_reg1 ? `VIP_EDGE_FALL : `VIP_EDGE_NONE),
    (key_return_mode_reg0 ? `VIP_EDGE_FALL : `VIP_EDGE_NONE),
    ext_edge_mode_reg1,
    ext_edge_mode_reg0
  };

  vip_pin_edge u_pin_edge (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin_in(pin_raw),
    .edge_mode(pin_mode),
    .edge_pulse(pin_edge)
  );

  ////////////////////////////////////////////////////////////////
  // watchdog routing
  // RULE8 one path only
  assign wdt_nmi_mode = (wdt_mode == `VIP_WDT_MODE1);
  // RULE6 nmi on mode 1
  assign wdt_nmi_event = watchdog_irq & wdt_nmi_mode;
  // RULE7 interval mode maskable
  assign wdt_mask_event = watchdog_irq & ~wdt_nmi_mode;

  ////////////////////////////////////////////////////////////////
  // timer level 12 source
  // RULE14 combined cascade match
  assign cascade_match = timer_b_match_irq & timer_c_match_irq;
  assign tmc_event = timer_cascade ? cascade_match : timer_c_match_irq;

  ////////////////////////////////////////////////////////////////
  // source map: bit index is the default priority level
  // RULE7 level 0
  assign src_event[`VIP_I_WDT] = wdt_mask_event;
  // RULE9 levels 1 to 4
  assign src_event[`VIP_I_PIN0+3:`VIP_I_PIN0] = pin_edge[3:0];
  // RULE10 remote edge
  assign src_event[`VIP_I_REMEDGE] = remote_edge_irq;
  // RULE11 shared serial request
  assign src_event[`VIP_I_SER] = serial_rx_done_irq | serial_3wire_done_irq;
  // RULE12 second 3-wire unit
  assign src_event[`VIP_I_SER2] = second_3wire_done_irq;
  // RULE13 levels 8 to 15
  assign src_event[`VIP_I_TX] = serial_tx_done_irq;
  assign src_event[`VIP_I_WINT] = watch_interval_irq;
  assign src_event[`VIP_I_TMA] = timer_a_match_irq;
  assign src_event[`VIP_I_TMB] = timer_b_match_irq;
  assign src_event[`VIP_I_TMC] = tmc_event;
  assign src_event[`VIP_I_TMD] = timer_d_match_irq;
  assign src_event[`VIP_I_ADC] = adc_done_irq;
  assign src_event[`VIP_I_WOVF] = watch_overflow_irq;
  // RULE15 first key return
  assign src_event[`VIP_I_KEY0] = pin_edge[4];
  // RULE16 remote receiver levels
  assign src_event[`VIP_I_RERR] = remote_error_irq;
  assign src_event[`VIP_I_RGUIDE] = remote_guide_irq;
  assign src_event[`VIP_I_REND] = remote_end_irq;
  assign src_event[`VIP_I_RFULL] = remote_shift_full_irq;
  // RULE5 extra key return at 21
  assign src_event[`VIP_I_KEY1] = pin_edge[5];

  // RULE4 variant source set
  // the smaller part has no second key return; its flag stays clear
  assign src_valid = LARGE_VARIANT ? {`VIP_NSRC{1'b1}} :
                     {1'b0, {(`VIP_NSRC-1){1'b1}}};

  ////////////////////////////////////////////////////////////////
  // acknowledge decode
  // the cpu acks what is on irq_index_reg in the same cycle
  assign ack_nmi = cpu_ack & irq_req_reg & irq_nmi_reg;
  assign ack_mask = cpu_ack & irq_req_reg & ~irq_nmi_reg;

  ////////////////////////////////////////////////////////////////
  // request flags, one per source
  genvar g;
  generate
    for (g = 0; g < `VIP_NSRC; g = g + 1) begin : g_flag
      localparam [`VIP_IDXW-1:0] LVL = g;
      wire base;
      assign ack_hit[g] = ack_mask & (irq_index_reg == LVL);
      assign base = flag_wr ? flag_wdata[g] : req_flag_reg[g];
      // RULE17 set beats clear
      assign flag_next[g] = src_valid[g] & ((base & ~ack_hit[g]) | src_event[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // mask flags; unused bit of the small part reads as masked
  assign mask_next = mask_wr ? (mask_wdata | ~src_valid) : mask_flag_reg;

  ////////////////////////////////////////////////////////////////
  // non-maskable pending state
  // RULE19 unconditional nmi
  assign nmi_pend_next = (nmi_pend_reg & ~ack_nmi) | wdt_nmi_event;

  ////////////////////////////////////////////////////////////////
  // selection works on next-state values so the presented vector
  // drops in the same edge that a flag clears, avoiding double acks
  // RULE1 mask gate
  assign live = flag_next & ~mask_next;

  // RULE2 fixed priority
  vip_prio_enc u_prio_enc (
    .req(live),
    .found(enc_found),
    .index(enc_index)
  );

  // RULE19 nmi outranks maskable
  assign nmi_next = nmi_pend_next;
  assign sel_index = nmi_next ? {`VIP_IDXW{1'b0}} : enc_index;
  // RULE20 enable gates maskable only
  assign req_next = nmi_next | (enc_found & global_irq_enable);
  // RULE13 two-byte vector step
  assign vector_next = nmi_next ? `VIP_VEC_NMI :
                       (`VIP_VEC_BASE + {10'h000, enc_index, 1'b0});
  // RULE3 standby release
  // wake-up ignores the global enable so a halted core can resume
  assign standby_next = nmi_next | enc_found;

  ////////////////////////////////////////////////////////////////
  // state and outputs
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      req_flag_reg <= `VIP_FLAG_RST;
      // RULE18 all masked
      mask_flag_reg <= `VIP_MASK_RST;
      nmi_pend_reg <= 1'b0;
      irq_req_reg <= 1'b0;
      irq_nmi_reg <= 1'b0;
      irq_index_reg <= {`VIP_IDXW{1'b0}};
      irq_vector_reg <= 16'h0000;
      standby_release_reg <= 1'b0;
    end else begin
      req_flag_reg <= flag_next;
      mask_flag_reg <= mask_next;
      nmi_pend_reg <= nmi_pend_next;
      irq_req_reg <= req_next;
      irq_nmi_reg <= nmi_next;
      irq_index_reg <= sel_index;
      irq_vector_reg <= req_next ? vector_next : 16'h0000;
      standby_release_reg <= standby_next;
    end
  end

endmodule
`default_nettype wire

/* test/vip_irq_props.sv */
// checker for the vectored interrupt priority logic
// assumes it is bound to vip_irq_ctrl and sees only its ports
`timescale 1ns/100ps
`default_nettype none
`include "vip_defs.vh"
module vip_irq_props (
  input wire ref_clk,
  input wire rstn,
  input wire watchdog_irq,
  input wire wdt_mode,
  input wire flag_wr,
  input wire global_irq_enable,
  input wire cpu_ack,
  input wire irq_req_reg,
  input wire irq_nmi_reg,
  input wire [`VIP_IDXW-1:0] irq_index_reg,
  input wire [15:0] irq_vector_reg,
  input wire standby_release_reg,
  input wire [`VIP_NSRC-1:0] req_flag_reg,
  input wire [`VIP_NSRC-1:0] mask_flag_reg,
  input wire nmi_pend_reg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire shown = irq_req_reg && !irq_nmi_reg;
  ////////////////////////////////////////////////////////////
  property p_nmi; watchdog_irq && wdt_mode |=> nmi_pend_reg && irq_nmi_reg && irq_vector_reg == `VIP_VEC_NMI; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not presented");
  property p_wdt_mask; watchdog_irq && !wdt_mode |=> req_flag_reg[0]; endproperty
  a_wdt_mask: assert property (p_wdt_mask) else $error("interval overflow flag missing");
  // a flag write can set bit 0 beside the nmi, so compare only without a flag write
  property p_one_path; watchdog_irq && !nmi_pend_reg && !req_flag_reg[0] && !flag_wr |=> nmi_pend_reg != req_flag_reg[0];
  endproperty
  a_one_path: assert property (p_one_path) else $error("watchdog path count wrong");
  property p_masked; shown && $stable(mask_flag_reg) |-> !mask_flag_reg[irq_index_reg] && req_flag_reg[irq_index_reg];
  endproperty
  a_masked: assert property (p_masked) else $error("masked or idle source shown");
  property p_vector; shown |-> irq_vector_reg == 16'h0004 + {10'h000, irq_index_reg, 1'b0}; endproperty
  a_vector: assert property (p_vector) else $error("vector does not match index");
  property p_prio; shown && $stable(mask_flag_reg) |-> (req_flag_reg & ~mask_flag_reg & ((22'h1 << irq_index_reg) - 22'h1)) == 22'h0;
  endproperty
  a_prio: assert property (p_prio) else $error("higher priority source skipped");
  property p_enable; !$past(global_irq_enable) |-> !shown; endproperty
  a_enable: assert property (p_enable) else $error("maskable shown while disabled");
  property p_standby; standby_release_reg == (nmi_pend_reg || |(req_flag_reg & ~mask_flag_reg)); endproperty
  a_standby: assert property (p_standby) else $error("standby release wrong");
  property p_ack_nmi; irq_nmi_reg && cpu_ack && !watchdog_irq |=> !nmi_pend_reg; endproperty
  a_ack_nmi: assert property (p_ack_nmi) else $error("nmi not cleared by ack");
endmodule
`default_nettype wire

/* test/vip_cpu_model.sv */
// cpu core model: takes one presented vector at a time and acks it
// assumes registered vectors on ref_clk; acts on the falling edge
`timescale 1ns/100ps
`default_nettype none
module vip_cpu_model (
  input wire ref_clk,
  input wire rstn,
  input wire run,
  input wire [3:0] ack_delay,
  input wire irq_req_reg,
  input wire [15:0] irq_vector_reg,
  output var logic cpu_ack,
  output var int n_ack,
  output var logic [15:0] vec_log [0:31]
);
  int wait_cnt;
  // ack lasts one cycle, so the core never takes the next winner twice
  always @(negedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_ack <= 1'b0;
      n_ack <= 0;
      wait_cnt <= 0;
    end else if (cpu_ack || !run || irq_req_reg !== 1'b1) begin
      cpu_ack <= 1'b0;
      wait_cnt <= 0;
    end else if (wait_cnt >= ack_delay) begin
      cpu_ack <= 1'b1;
      vec_log[n_ack[4:0]] <= irq_vector_reg;
      n_ack <= n_ack + 1;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule
`default_nettype wire

/* test/vip_irq_ctrl_bench.sv */
// self-checking bench for the vectored interrupt priority logic
// assumes the cpu model and all stimulus move on the falling edge
`timescale 1ns/100ps
`default_nettype none
`include "vip_defs.vh"
module vip_irq_ctrl_bench;
  localparam LARGE_VARIANT = 1;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic wdt_mode = 1'b0;
  logic alt = 1'b0;
  logic timer_cascade = 1'b0;
  logic flag_wr = 1'b0;
  logic mask_wr = 1'b0;
  logic global_irq_enable = 1'b0;
  logic run = 1'b0;
  logic [3:0] ack_delay = 4'h0;
  logic [5:0] pins = 6'h3F;
  logic [21:0] ev = 22'h0;
  logic [21:0] flag_wdata = 22'h0;
  logic [21:0] mask_wdata = 22'h0;
  wire cpu_ack;
  wire irq_req_reg, irq_nmi_reg, standby_release_reg, nmi_pend_reg;
  wire [4:0] irq_index_reg;
  wire [15:0] irq_vector_reg;
  wire [21:0] req_flag_reg, mask_flag_reg;
  int n_ack;
  logic [15:0] vec_log [0:31];
  int errors = 0;
  int n_checks = 0;
  // each row: {second serial event, source, expected vector}
  logic [21:0] rows [0:16] = '{22'h000004, 22'h05000E, 22'h060010, 22'h260010, 22'h070012, 22'h080014,
    22'h090016, 22'h0A0018, 22'h0B001A, 22'h0C001C, 22'h0D001E, 22'h0E0020, 22'h0F0022, 22'h110026,
    22'h120028, 22'h13002A, 22'h14002C};
  always #10 ref_clk = ~ref_clk;
  vip_irq_ctrl #(.LARGE_VARIANT(LARGE_VARIANT)) u_dut (.ref_clk, .rstn, .watchdog_irq(ev[0]), .wdt_mode,
    .ext_pin0(pins[0]), .ext_pin1(pins[1]), .ext_pin2(pins[2]), .ext_pin3(pins[3]), .key_pin0(pins[4]),
    .key_pin1(pins[5]), .ext_edge_mode_reg0(2'h0), .ext_edge_mode_reg1(6'h00), .key_return_mode_reg0(1'b1),
    .key_return_mode_reg1(1'b1), .remote_edge_irq(ev[5]), .serial_rx_done_irq(ev[6]), .serial_3wire_done_irq(alt),
    .second_3wire_done_irq(ev[7]), .serial_tx_done_irq(ev[8]), .watch_interval_irq(ev[9]),
    .timer_a_match_irq(ev[10]), .timer_b_match_irq(ev[11]), .timer_c_match_irq(ev[12]),
    .timer_d_match_irq(ev[13]), .timer_cascade, .adc_done_irq(ev[14]), .watch_overflow_irq(ev[15]),
    .remote_error_irq(ev[17]), .remote_guide_irq(ev[18]), .remote_end_irq(ev[19]),
    .remote_shift_full_irq(ev[20]), .flag_wr, .flag_wdata, .mask_wr, .mask_wdata, .global_irq_enable,
    .cpu_ack, .irq_req_reg, .irq_nmi_reg, .irq_index_reg, .irq_vector_reg, .standby_release_reg,
    .req_flag_reg, .mask_flag_reg, .nmi_pend_reg);
  vip_cpu_model u_cpu (.ref_clk, .rstn, .run, .ack_delay, .irq_req_reg, .irq_vector_reg, .cpu_ack,
    .n_ack, .vec_log);
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic pulse(input logic [21:0] e, input logic a);
    ev = e;
    alt = a;
    @(negedge ref_clk);
    ev = 22'h0;
    alt = 1'b0;
  endtask
  task automatic wr_flags(input logic [21:0] v);
    flag_wdata = v;
    flag_wr = 1'b1;
    @(negedge ref_clk);
    flag_wr = 1'b0;
  endtask
  // bounded wait: a stalled handshake ends the run instead of hanging
  task automatic wait_acks(input int n);
    for (int i = 0; i < 300 && n_ack < n; i++) @(negedge ref_clk);
    chk("ack count", n, n_ack);
    if (n_ack < n) give_verdict;
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    global_irq_enable = 1'b1;
    mask_wr = 1'b1;
    @(negedge ref_clk);
    mask_wr = 1'b0;
    for (int r = 0; r < 17; r++) begin
      pulse(rows[r][21] ? 22'h0 : 22'h1 << rows[r][20:16], rows[r][21]);
      chk("vector", rows[r][15:0], irq_vector_reg);
      wr_flags(22'h0);
    end
    rstn = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("mask reset", `VIP_MASK_RST, mask_flag_reg);
    chk("flag reset", `VIP_FLAG_RST, req_flag_reg);
    rstn = 1'b1;
    pulse(22'h000400, 1'b0);
    chk("masked flag", 22'h000400, req_flag_reg);
    chk("masked req", 1'b0, irq_req_reg);
    chk("masked standby", 1'b0, standby_release_reg);
    mask_wr = 1'b1;
    @(negedge ref_clk);
    mask_wr = 1'b0;
    chk("unmasked vector", 16'h0018, irq_vector_reg);
    chk("standby", 1'b1, standby_release_reg);
    wr_flags(22'h0);
    global_irq_enable = 1'b0;
    pins = 6'h00;
    pulse(22'h1EFFE1, 1'b1);
    repeat (5) @(negedge ref_clk);
    chk("all flags", 22'h3FFFFF, req_flag_reg);
    chk("disabled req", 1'b0, irq_req_reg);
    global_irq_enable = 1'b1;
    ack_delay = 4'h3;
    run = 1'b1;
    wait_acks(22);
    for (int k = 0; k < 22; k++) chk("ack order", 16'h0004 + 2 * k, vec_log[k]);
    run = 1'b0;
    pins = 6'h3F;
    timer_cascade = 1'b1;
    pulse(22'h000800, 1'b0);
    chk("cascade single", 22'h000800, req_flag_reg);
    pulse(22'h001800, 1'b0);
    chk("cascade pair", 22'h001800, req_flag_reg);
    timer_cascade = 1'b0;
    wr_flags(22'h000400);
    wdt_mode = 1'b1;
    pulse(22'h000001, 1'b0);
    chk("nmi shown", 1'b1, irq_nmi_reg);
    chk("nmi vector", 16'h0004, irq_vector_reg);
    chk("no maskable wdt", 22'h000400, req_flag_reg);
    ack_delay = 4'h0;
    run = 1'b1;
    wait_acks(24);
    chk("nmi first", 16'h0004, vec_log[22]);
    chk("then timer", 16'h0018, vec_log[23]);
    chk("nmi cleared", 1'b0, nmi_pend_reg);
    give_verdict;
  end
endmodule
bind vip_irq_ctrl vip_irq_props u_props (.ref_clk, .rstn, .watchdog_irq, .wdt_mode, .flag_wr, .global_irq_enable,
  .cpu_ack, .irq_req_reg, .irq_nmi_reg, .irq_index_reg, .irq_vector_reg, .standby_release_reg, .req_flag_reg,
  .mask_flag_reg, .nmi_pend_reg);
`default_nettype wire
